// File: verilog/ctx_exec.sv
// Execution slice: table write, test-skip, exclusive-OR, pointer literals
//
// Behaviour
// - 0000 0000 0000 11nn is table write, 2 cycles, nn picks pointer step.
// - Table write copies latch byte into buffer chosen by pointer low bits.
// - Byte pointer is 21 bits wide over 2 MB program space.
// - Pointer bit 0 picks low byte (0) or high byte (1).
// - Table write never changes arithmetic flags.
// - Opcode 0110 011a test-skip; zero register discards next, two cycles.
// - Skipping a two-word instruction takes three cycles total.
// - Bank bit 0 uses access bank, 1 uses bank select register.
// - a=0, extended on, operand up to 95 means indexed offset from pointer.
// - Opcode 0000 1010 k xors literal into W, one cycle, sets N and Z.
// - Opcode 0001 10da xors W with file register, one cycle, N and Z only.
// - Destination bit 0 writes W, 1 writes the file register back.
// - Extended features off after reset until config bit set to 1.
// - Extended set adds eight literal ops to the 75 standard instructions.
// - Pointer add and subtract have third-pointer auto-return variants.
// - Pointer add adds 6-bit literal to chosen pointer, flags untouched.
// - Auto-return variant is field 11, two cycles, second one a no-op.
`include "ctx_regs.svh"
module ctx_exec #(
  parameter int DMEM_AW = 4,
  parameter int WBUF_N = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import ctx_pkg::*;

  localparam int DMEM_N = 1 << DMEM_AW;

  // ===================================================================
  // State
  typedef struct packed {
    ctx_state_e st;
    logic [1:0] left;
    logic [1:0] cyc;
    logic skip;
    logic [7:0] w;
    logic [7:0] latch;
    logic [20:0] ptr;
    logic [3:0] bank;
    logic flag_n;
    logic flag_z;
    logic ext;
    logic [2:0][11:0] sel;
    logic [20:0] ret_top;
    logic [20:0] pc;
    logic [WBUF_N-1:0][7:0] wbuf;
    logic [DMEM_N-1:0][7:0] dmem;
    logic [31:0] rdata;
  } ctx_state_s;

  ctx_state_s s_q;
  ctx_state_s s_d;

  // ===================================================================
  // Decoding, used by the sequencer and by the checks
  function automatic ctx_op_e ctx_decode(input logic [15:0] i,
                                         input logic ext);
    ctx_op_e op;
    op = CTX_OP_NOP;
    if (i[15:2] == 14'h0003) begin
      op = CTX_OP_TABWR;
    end else if (i[15:9] == 7'h33) begin
      op = CTX_OP_TST;
    end else if (i[15:8] == 8'h0a) begin
      op = CTX_OP_XORL;
    end else if (i[15:10] == 6'h06) begin
      op = CTX_OP_XORF;
    end else if (ext && i[15:8] == 8'he8) begin
      op = (i[7:6] == 2'h3) ? CTX_OP_PADDR : CTX_OP_PADD;
    end else if (ext && i[15:8] == 8'he9) begin
      op = (i[7:6] == 2'h3) ? CTX_OP_PSUBR : CTX_OP_PSUB;
    end
    return op;
  endfunction

  // Effective data address of a byte-oriented operand
  function automatic logic [11:0] ctx_addr(input logic [7:0] f,
                                           input logic a,
                                           input logic ext,
                                           input logic [3:0] bank,
                                           input logic [11:0] base);
    logic [11:0] r;
    r = {bank, f};
    if (!a) begin
      if (ext && f < `CTX_ACCESS_SPLIT) begin
        r = base + {4'h0, f};
      end else if (f < `CTX_ACCESS_SPLIT) begin
        r = {4'h0, f};
      end else begin
        r = {`CTX_ACCESS_HIGH_BANK, f};
      end
    end
    return r;
  endfunction

  // ===================================================================
  // Bus decode
  logic acc;
  logic wr;
  logic go;
  logic refuse;
  logic unmapped;
  ctx_op_e op;
  logic [11:0] ea;
  logic [DMEM_AW-1:0] di;
  logic [7:0] fval;
  logic [7:0] xres;
  logic [20:0] ptr_pre;
  logic [11:0] lit;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign unmapped = !(paddr[11:2] <= 10'(`CTX_OFS_COMMIT >> 2) ||
    (paddr >= `CTX_OFS_WBUF && paddr < `CTX_OFS_WBUF + 12'(4 * WBUF_N)) ||
    (paddr >= `CTX_OFS_DMEM && paddr < `CTX_OFS_DMEM + 12'(4 * DMEM_N)));
  // An instruction written while one is still running is refused
  assign refuse = wr && paddr == `CTX_OFS_INSTR && s_q.st == CTX_ST_BUSY;
  assign go = wr && paddr == `CTX_OFS_INSTR && s_q.st == CTX_ST_IDLE;
  assign op = ctx_decode(pwdata[15:0], s_q.ext);
  assign ea = ctx_addr(pwdata[7:0], pwdata[8], s_q.ext, s_q.bank,
    s_q.sel[2]);
  // Only the low address bits reach the small data store
  assign di = ea[DMEM_AW-1:0];
  assign fval = s_q.dmem[di];
  assign xres = s_q.w ^ (op == CTX_OP_XORL ? pwdata[7:0] : fval);
  assign ptr_pre = s_q.ptr + 21'h1;
  assign lit = {6'h00, pwdata[5:0]};
  assign pready = 1'b1;
  assign pslverr = acc && (unmapped || refuse);
  assign prdata = s_q.rdata;

  // ===================================================================
  // Next state
  always_comb begin
    logic [2:0] wi;
    logic [1:0] pi;
    s_d = s_q;
    wi = 3'h0;
    pi = 2'h0;
    s_d.rdata = 32'h0000_0000;
    if (s_q.st == CTX_ST_BUSY) begin
      s_d.left = s_q.left - 2'd1;
      if (s_q.left == 2'd1) begin
        s_d.st = CTX_ST_IDLE;
      end
    end
    if (go) begin
      s_d.cyc = `CTX_CYC_ONE;
      s_d.skip = 1'b0;
      s_d.pc = s_q.pc + 21'h2;
      case (op)
        CTX_OP_TABWR: begin
          s_d.cyc = `CTX_CYC_TWO;
          // Pre-increment moves the pointer before choosing the buffer
          wi = (pwdata[1:0] == 2'h3) ? ptr_pre[2:0] : s_q.ptr[2:0];
          s_d.wbuf[wi] = s_q.latch;
          case (pwdata[1:0])
            2'h1: s_d.ptr = ptr_pre;
            2'h2: s_d.ptr = s_q.ptr - 21'h1;
            2'h3: s_d.ptr = ptr_pre;
            default: s_d.ptr = s_q.ptr;
          endcase
        end
        CTX_OP_TST: begin
          if (fval == `CTX_RST_BYTE) begin
            // Skipped words are never executed, only stepped over
            s_d.skip = 1'b1;
            s_d.cyc = pwdata[`CTX_INSTR_TWO_WORD_BIT] ?
              `CTX_CYC_THREE : `CTX_CYC_TWO;
            s_d.pc = s_q.pc + (pwdata[`CTX_INSTR_TWO_WORD_BIT] ?
              21'h6 : 21'h4);
          end
        end
        CTX_OP_XORL, CTX_OP_XORF: begin
          s_d.flag_n = xres[7];
          s_d.flag_z = xres == `CTX_RST_BYTE;
          if (op == CTX_OP_XORF && pwdata[9]) begin
            s_d.dmem[di] = xres;
          end else begin
            s_d.w = xres;
          end
        end
        CTX_OP_PADD, CTX_OP_PSUB: begin
          pi = pwdata[7:6];
          if (op == CTX_OP_PADD) begin
            s_d.sel[pi] = s_q.sel[pi] + lit;
          end else begin
            s_d.sel[pi] = s_q.sel[pi] - lit;
          end
        end
        CTX_OP_PADDR, CTX_OP_PSUBR: begin
          s_d.cyc = `CTX_CYC_TWO;
          s_d.pc = s_q.ret_top;
          if (op == CTX_OP_PADDR) begin
            s_d.sel[2] = s_q.sel[2] + lit;
          end else begin
            s_d.sel[2] = s_q.sel[2] - lit;
          end
        end
        default: begin
        end
      endcase
      s_d.left = s_d.cyc;
      s_d.st = CTX_ST_BUSY;
    end else if (wr && !unmapped && s_q.st == CTX_ST_IDLE) begin
      case (paddr)
        `CTX_OFS_WREG: s_d.w = pwdata[7:0];
        `CTX_OFS_LATCH: s_d.latch = pwdata[7:0];
        `CTX_OFS_PTR: s_d.ptr = pwdata[20:0];
        `CTX_OFS_BANK: s_d.bank = pwdata[3:0];
        `CTX_OFS_FLAGS: begin
          s_d.flag_n = pwdata[`CTX_FLAG_N_BIT];
          s_d.flag_z = pwdata[`CTX_FLAG_Z_BIT];
        end
        `CTX_OFS_CFG: s_d.ext = pwdata[0];
        `CTX_OFS_SEL0: s_d.sel[0] = pwdata[11:0];
        `CTX_OFS_SEL1: s_d.sel[1] = pwdata[11:0];
        `CTX_OFS_SEL2: s_d.sel[2] = pwdata[11:0];
        `CTX_OFS_RTOP: s_d.ret_top = pwdata[20:0];
        `CTX_OFS_PC: s_d.pc = pwdata[20:0];
        `CTX_OFS_COMMIT: begin
          // A completed flash write leaves every buffer erased
          for (int k = 0; k < WBUF_N; k++) begin
            s_d.wbuf[k] = `CTX_ERASED_BYTE;
          end
        end
        default: begin
          if (paddr >= `CTX_OFS_DMEM) begin
            s_d.dmem[paddr[DMEM_AW+1:2]] = pwdata[7:0];
          end
        end
      endcase
    end
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `CTX_OFS_WREG: s_d.rdata = {24'h0, s_q.w};
        `CTX_OFS_LATCH: s_d.rdata = {24'h0, s_q.latch};
        `CTX_OFS_PTR: s_d.rdata = {11'h0, s_q.ptr};
        `CTX_OFS_BANK: s_d.rdata = {28'h0, s_q.bank};
        `CTX_OFS_FLAGS: s_d.rdata = {27'h0, s_q.flag_n, 1'b0,
          s_q.flag_z, 2'h0};
        `CTX_OFS_CFG: s_d.rdata = {31'h0, s_q.ext};
        `CTX_OFS_SEL0: s_d.rdata = {20'h0, s_q.sel[0]};
        `CTX_OFS_SEL1: s_d.rdata = {20'h0, s_q.sel[1]};
        `CTX_OFS_SEL2: s_d.rdata = {20'h0, s_q.sel[2]};
        `CTX_OFS_RTOP: s_d.rdata = {11'h0, s_q.ret_top};
        `CTX_OFS_PC: s_d.rdata = {11'h0, s_q.pc};
        `CTX_OFS_STAT: s_d.rdata = {26'h0, s_q.cyc, 2'h0, s_q.skip,
          s_q.st == CTX_ST_BUSY};
        default: begin
          if (paddr >= `CTX_OFS_DMEM &&
              paddr < `CTX_OFS_DMEM + 12'(4 * DMEM_N)) begin
            s_d.rdata = {24'h0, s_q.dmem[paddr[DMEM_AW+1:2]]};
          end else if (paddr >= `CTX_OFS_WBUF &&
                       paddr < `CTX_OFS_WBUF + 12'(4 * WBUF_N)) begin
            s_d.rdata = {24'h0, s_q.wbuf[paddr[4:2]]};
          end
        end
      endcase
    end
  end

  // ===================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= CTX_ST_IDLE;
      s_q.ext <= 1'b0;
      s_q.wbuf <= {WBUF_N{`CTX_ERASED_BYTE}};
    end else begin
      s_q <= s_d;
    end
  end

  // ===================================================================
  // Checks
  AST_TABWR_CYC: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && op == CTX_OP_TABWR |=> s_q.left == 2'd2 ##1 s_q.left == 2'd1
    ##1 s_q.st == CTX_ST_IDLE)
    else $error("table write did not take two cycles");
  AST_TABWR_BUF: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && op == CTX_OP_TABWR && pwdata[1:0] == 2'h0
    |=> s_q.wbuf[$past(s_q.ptr[2:0])] == $past(s_q.latch))
    else $error("latch byte not in chosen buffer");
  AST_TABWR_PRE: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && op == CTX_OP_TABWR && pwdata[1:0] == 2'h3
    |=> s_q.ptr == $past(s_q.ptr) + 21'h1 &&
        s_q.wbuf[s_q.ptr[2:0]] == $past(s_q.latch))
    else $error("pre-increment wrote wrong buffer");
  AST_TABWR_DEC: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && op == CTX_OP_TABWR && pwdata[1:0] == 2'h2
    |=> s_q.ptr == $past(s_q.ptr) - 21'h1)
    else $error("post-decrement wrong");
  AST_TABWR_FLAGS: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && op == CTX_OP_TABWR |=> $stable(s_q.flag_n) &&
    $stable(s_q.flag_z))
    else $error("table write changed flags");
  AST_SKIP_CYC: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && op == CTX_OP_TST && fval == 8'h00
    |=> s_q.cyc == ($past(pwdata[16]) ? 2'd3 : 2'd2))
    else $error("skip cycle count wrong");
  AST_SKIP_CLEAN: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && op == CTX_OP_TST |=> $stable(s_q.w) && $stable(s_q.dmem) &&
    $stable(s_q.sel) && $stable(s_q.flag_z) && $stable(s_q.flag_n) &&
    $stable(s_q.ptr))
    else $error("test-skip had side effects");
  AST_XORL: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && op == CTX_OP_XORL |=> s_q.w == ($past(s_q.w) ^ $past(pwdata[7:0]))
    && s_q.flag_z == (s_q.w == 8'h00) && s_q.cyc == 2'd1)
    else $error("literal xor wrong");
  AST_XORF_DEST: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && op == CTX_OP_XORF && pwdata[9] |=> $stable(s_q.w) &&
    s_q.flag_n == s_q.dmem[$past(di)][7])
    else $error("register xor destination wrong");
  AST_EXT_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && !s_q.ext && pwdata[15:9] == 7'h74 |=> $stable(s_q.sel))
    else $error("extended op acted while disabled");
  AST_RET: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && (op == CTX_OP_PADDR || op == CTX_OP_PSUBR)
    |=> s_q.pc == $past(s_q.ret_top) && s_q.cyc == 2'd2)
    else $error("auto-return wrong");
  AST_PTR_FLAGS: assert property (
    @(posedge pclk) disable iff (!presetn)
    go && (op == CTX_OP_PADD || op == CTX_OP_PSUB) |=> $stable(s_q.flag_n)
    && $stable(s_q.flag_z))
    else $error("pointer literal op changed flags");
endmodule

// File: pkg/ctx_regs.svh
// Register offsets, reset values and cycle counts of the execution slice
`ifndef CTX_REGS_SVH
`define CTX_REGS_SVH
// =====================================================================
// Register byte offsets
`define CTX_OFS_INSTR 12'h000
`define CTX_OFS_WREG 12'h004
`define CTX_OFS_LATCH 12'h008
`define CTX_OFS_PTR 12'h00c
`define CTX_OFS_BANK 12'h010
`define CTX_OFS_FLAGS 12'h014
`define CTX_OFS_CFG 12'h018
`define CTX_OFS_SEL0 12'h01c
`define CTX_OFS_SEL1 12'h020
`define CTX_OFS_SEL2 12'h024
`define CTX_OFS_RTOP 12'h028
`define CTX_OFS_PC 12'h02c
`define CTX_OFS_STAT 12'h030
`define CTX_OFS_COMMIT 12'h034
`define CTX_OFS_WBUF 12'h040
`define CTX_OFS_DMEM 12'h080
// =====================================================================
// Field positions
`define CTX_INSTR_TWO_WORD_BIT 16
`define CTX_FLAG_N_BIT 4
`define CTX_FLAG_Z_BIT 2
`define CTX_STAT_BUSY_BIT 0
`define CTX_STAT_SKIP_BIT 1
`define CTX_STAT_CYC_LSB 4
// =====================================================================
// Reset values and cycle counts
`define CTX_RST_BYTE 8'h00
`define CTX_ERASED_BYTE 8'hff
`define CTX_CYC_ONE 2'd1
`define CTX_CYC_TWO 2'd2
`define CTX_CYC_THREE 2'd3
`define CTX_ACCESS_SPLIT 8'h60
`define CTX_ACCESS_HIGH_BANK 4'hf
`endif

// File: pkg/ctx_pkg.sv
// Types shared by the execution slice
package ctx_pkg;
  // ===================================================================
  // Decoded operations
  typedef enum logic [3:0] {
    CTX_OP_NOP,
    CTX_OP_TABWR,
    CTX_OP_TST,
    CTX_OP_XORL,
    CTX_OP_XORF,
    CTX_OP_PADD,
    CTX_OP_PSUB,
    CTX_OP_PADDR,
    CTX_OP_PSUBR
  } ctx_op_e;
  // ===================================================================
  // Sequencer states
  typedef enum logic {
    CTX_ST_IDLE,
    CTX_ST_BUSY
  } ctx_state_e;
endpackage

// File: bench/ctx_apb_host.sv
// APB master model standing in for software on the register bus
module ctx_apb_host (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // ===================================================================
  // One transfer: setup, then access until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until the edge that samples pready high
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q,
                    output logic e);
    xfer(1'b0, a, 32'h00000000, q, e);
  endtask
endmodule

// File: bench/ctx_exec_bench.sv
// Self-checking bench for the execution slice, driven over APB
`include "ctx_regs.svh"
module ctx_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic s;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  logic [20:0] tp[4] = '{21'h0a350, 21'h0a356, 21'h0a355, 21'h1389a};
  logic [7:0] lb[4] = '{8'h11, 8'h55, 8'h22, 8'h34};
  logic [20:0] ep;
  // ===================================================================
  // Design and bus master
  ctx_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ctx_apb_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  always #2 pclk = ~pclk;
  // Hang guard, far above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  // ===================================================================
  // Helpers
  task automatic close_out();
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input string nm);
    logic [31:0] q;
    logic x;
    host.rd(a, q, x);
    chk(nm, e, q);
  endtask
  // Issue one instruction, then poll busy under a bounded count
  task automatic ex(input logic [31:0] op);
    logic [31:0] q;
    logic x;
    host.wr(`CTX_OFS_INSTR, op);
    for (int i = 0; i < 20; i++) begin
      host.rd(`CTX_OFS_STAT, q, x);
      if (q[0] !== 1'b1) break;
    end
    chk("busy", 32'h0, {31'h0, q[0]});
  endtask
  // Program counter advance and status of one instruction
  task automatic pcd(input logic [31:0] op, input logic [20:0] dl,
                     input logic [31:0] st);
    logic [31:0] p;
    logic x;
    host.rd(`CTX_OFS_PC, p, x);
    ex(op);
    rdc(`CTX_OFS_PC, {11'h000, p[20:0] + dl}, "pc");
    rdc(`CTX_OFS_STAT, st, "stat");
  endtask
  // ===================================================================
  // Tests
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`CTX_OFS_CFG, 32'h0, "cfg");
    for (int i = 0; i < 8; i++)
      rdc(12'h040 + 12'(4 * i), 32'hff, "wbuf");
    host.wr(`CTX_OFS_PTR, 32'hffffffff);
    rdc(`CTX_OFS_PTR, 32'h1fffff, "ptr");
    host.wr(`CTX_OFS_WREG, 32'hb5);
    ex(32'h0aaf);
    rdc(`CTX_OFS_WREG, 32'h1a, "w");
    rdc(`CTX_OFS_STAT, 32'h10, "stat");
    ex(32'h0a1a);
    rdc(`CTX_OFS_FLAGS, 32'h04, "flags");
    ex(32'h0a80);
    rdc(`CTX_OFS_FLAGS, 32'h10, "flags");
    // Every pointer mode; pre-increment picks the buffer after the step
    for (int n = 0; n < 4; n++) begin
      host.wr(`CTX_OFS_PTR, {11'h000, tp[n]});
      host.wr(`CTX_OFS_LATCH, {24'h0, lb[n]});
      ex(32'h000c + n);
      ep = (n == 2) ? tp[n] - 21'd1 : (n == 0) ? tp[n] : tp[n] + 21'd1;
      rdc(`CTX_OFS_PTR, {11'h000, ep}, "ptr");
      rdc(12'h040 + {7'h0, (n == 3 ? ep[2:0] : tp[n][2:0]), 2'b00},
          {24'h0, lb[n]}, "wbuf");
      rdc(`CTX_OFS_STAT, 32'h20, "stat");
      rdc(`CTX_OFS_FLAGS, 32'h10, "flags");
    end
    host.wr(`CTX_OFS_COMMIT, 32'h1);
    rdc(12'h058, 32'hff, "wbuf");
    // Banked register exclusive-OR, both destinations
    host.wr(`CTX_OFS_BANK, 32'h2);
    host.wr(12'h08c, 32'haf);
    host.wr(`CTX_OFS_WREG, 32'hb5);
    ex(32'h1b03);
    rdc(12'h08c, 32'h1a, "dmem");
    rdc(`CTX_OFS_WREG, 32'hb5, "w");
    rdc(`CTX_OFS_FLAGS, 32'h00, "flags");
    ex(32'h1903);
    rdc(`CTX_OFS_WREG, 32'haf, "w");
    rdc(`CTX_OFS_FLAGS, 32'h10, "flags");
    // Test and skip: no skip, skip, skip over a two-word instruction
    pcd(32'h6703, 21'd2, 32'h10);
    host.wr(12'h08c, 32'h0);
    pcd(32'h6703, 21'd4, 32'h22);
    pcd(32'h16703, 21'd6, 32'h32);
    rdc(`CTX_OFS_WREG, 32'haf, "w");
    // Extended set off, then on
    host.wr(`CTX_OFS_SEL2, 32'h3ff);
    ex(32'he8a3);
    rdc(`CTX_OFS_SEL2, 32'h3ff, "sel2");
    host.wr(`CTX_OFS_CFG, 32'h1);
    ex(32'he8a3);
    rdc(`CTX_OFS_SEL2, 32'h422, "sel2");
    rdc(`CTX_OFS_FLAGS, 32'h10, "flags");
    ex(32'he9a3);
    rdc(`CTX_OFS_SEL2, 32'h3ff, "sel2");
    host.wr(`CTX_OFS_RTOP, 32'h100);
    ex(32'he8e3);
    rdc(`CTX_OFS_SEL2, 32'h422, "sel2");
    rdc(`CTX_OFS_PC, 32'h100, "pc");
    rdc(`CTX_OFS_STAT, 32'h20, "stat");
    ex(32'he9e3);
    rdc(`CTX_OFS_SEL2, 32'h3ff, "sel2");
    // Indexed offset: third pointer plus 5 lands on byte 4, not byte 5
    host.wr(12'h090, 32'h0f);
    host.wr(12'h094, 32'h00);
    ex(32'h1805);
    rdc(`CTX_OFS_WREG, 32'ha0, "w");
    // Unmapped place is refused and reads zero
    host.rd(12'h03c, v, s);
    chk("unmapped", 32'h0, v);
    chk("pslverr", 32'h1, {31'h0, s});
    // A second instruction while a three-cycle skip runs is refused
    host.wr(`CTX_OFS_INSTR, 32'h16606);
    host.xfer(1'b1, `CTX_OFS_INSTR, 32'h0a55, v, s);
    chk("refused", 32'h1, {31'h0, s});
    rdc(`CTX_OFS_WREG, 32'ha0, "w");
    // Reset in mid-run: buffers erased and the extended set off again
    ex(32'h000c);
    rdc(12'h04c, 32'h34, "wbuf");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h04c, 32'hff, "wbuf");
    rdc(`CTX_OFS_CFG, 32'h0, "cfg");
    close_out();
  end
endmodule
